//--- dcs_pkg.sv
package dcs_pkg;
  // ---------------------------------------------------------------
  // command opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_TEST_READY = 8'h00;
  localparam logic [7:0] OP_RECAL = 8'h01;
  localparam logic [7:0] OP_READ_STATUS = 8'h03;
  localparam logic [7:0] OP_FMT_DRIVE = 8'h04;
  localparam logic [7:0] OP_VERIFY = 8'h05;
  localparam logic [7:0] OP_FMT_TRACK = 8'h06;
  localparam logic [7:0] OP_FMT_BAD = 8'h07;
  localparam logic [7:0] OP_READ = 8'h08;
  localparam logic [7:0] OP_WRITE = 8'h0a;
  localparam logic [7:0] OP_SEEK = 8'h0b;

  // ---------------------------------------------------------------
  // returned error codes
  // ---------------------------------------------------------------
  localparam logic [5:0] ERR_NONE = 6'h00;
  localparam logic [5:0] ERR_WFAULT = 6'h03;
  localparam logic [5:0] ERR_NOT_READY = 6'h04;
  localparam logic [5:0] ERR_TRK0 = 6'h06;
  localparam logic [5:0] ERR_SEEKING = 6'h08;
  localparam logic [5:0] ERR_UNCORR = 6'h11;
  localparam logic [5:0] ERR_NO_DAM = 6'h12;
  localparam logic [5:0] ERR_SEEK = 6'h15;
  localparam logic [5:0] ERR_CORR = 6'h18;
  localparam logic [5:0] ERR_BAD_TRK = 6'h19;
  localparam logic [5:0] ERR_INV_CMD = 6'h20;
  localparam logic [5:0] ERR_ILL_ADDR = 6'h21;
  localparam logic [5:0] ERR_DIAG_BUF = 6'h30;
  localparam logic [5:0] ERR_DIAG_ROM = 6'h31;
  localparam logic [5:0] ERR_DIAG_ECC = 6'h32;

  // ---------------------------------------------------------------
  // status byte zero layout, counts and timing
  // ---------------------------------------------------------------
  localparam int ST0_AV_BIT = 7;
  localparam int STATUS_BYTES = 4;
  localparam logic [3:0] RETRY_LIMIT = 4'd10;
  localparam logic [8:0] SECTORS_PER_TRACK = 9'd17;
  localparam int TRK0_EXTRA_STEPS = 200;
  localparam int CLK_MHZ = 100;
  localparam int STEP_FAST_US = 70;
  localparam int STEP_MID_US = 200;
  localparam int STEP_SLOW_MS = 3;
  localparam int STEP_FAST_CYC = STEP_FAST_US * CLK_MHZ;
  localparam int STEP_MID_CYC = STEP_MID_US * CLK_MHZ;
  localparam int STEP_SLOW_CYC = STEP_SLOW_MS * 1000 * CLK_MHZ;
  localparam int STEP_PULSE_CYC = 4;
  localparam logic [2:0] STEP_CODE_200US = 3'b100;
  localparam logic [2:0] STEP_CODE_70US = 3'b101;
endpackage : dcs_pkg

//--- dcs_stepper.sv
`timescale 1ns/1ns
// step pulse generator; spacing set by the step code
module dcs_stepper
  import dcs_pkg::*;
#(
  parameter int SLOW_CYC = STEP_SLOW_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic [10:0] steps,
  input wire logic [2:0] step_code,
  input wire logic stop,
  output logic step_pulse,
  output logic busy
);
  // ---------------------------------------------------------------
  // spacing decode
  // ---------------------------------------------------------------
  logic [2:0] code_q;
  logic [19:0] space_cyc;
  assign space_cyc = (code_q == STEP_CODE_70US) ? 20'(STEP_FAST_CYC) :
                     (code_q == STEP_CODE_200US) ? 20'(STEP_MID_CYC) :
                     20'(SLOW_CYC);

  logic [10:0] left_q;
  logic [19:0] tmr_q;

  // counts steps left; stop aborts the train at once
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      left_q <= 11'h000;
      tmr_q <= 20'h00000;
      busy <= 1'b0;
      step_pulse <= 1'b0;
      code_q <= 3'h0;
    end else if (start) begin
      left_q <= steps;
      tmr_q <= 20'h00000;
      busy <= (steps != 11'h000);
      step_pulse <= 1'b0;
      code_q <= step_code;
    end else if (busy && stop) begin
      busy <= 1'b0;
      step_pulse <= 1'b0;
    end else if (busy) begin
      if (tmr_q == 20'h00000) begin
        step_pulse <= 1'b1;
        tmr_q <= space_cyc - 20'h00001;
        left_q <= left_q - 11'h001;
      end else begin
        if (tmr_q == space_cyc - 20'(STEP_PULSE_CYC)) step_pulse <= 1'b0;
        tmr_q <= tmr_q - 20'h00001;
        if (tmr_q == 20'h00001 && left_q == 11'h000) busy <= 1'b0;
      end
    end
  end
endmodule : dcs_stepper

//--- dcs_status_mem.sv
`timescale 1ns/1ns
// per-drive four byte status store, registered read
module dcs_status_mem (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic wr_drive,
  input wire logic [31:0] wr_data,
  input wire logic rd_drive,
  input wire logic [1:0] rd_idx,
  output logic [7:0] rd_data
);
  logic [31:0] mem_q [2];

  // ---------------------------------------------------------------
  // store and read
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_q[0] <= 32'h00000000;
      mem_q[1] <= 32'h00000000;
      rd_data <= 8'h00;
    end else begin
      if (wr_en) mem_q[wr_drive] <= wr_data;
      rd_data <= mem_q[rd_drive][8'(rd_idx) * 8 +: 8];
    end
  end
endmodule : dcs_status_mem

//--- dcs_unit.sv
`timescale 1ns/1ns
// Functional notes
// - read-status returns four bytes for named drive
// - byte zero holds address-valid flag and code
// - failed multi-sector transfer reports failing sector
// - format reports next or failing track; verify next or failing sector
// - format-drive recalibrates, seeks, formats each track through head 0 of last cylinder
// - format uses buffer data, starts sector zero
// - verify reads 1..256 sectors, stops on error
// - read 1..256 sectors, ends at error sector
// - write 1..256 sectors, same error handling
// - format-track writes ids, bad flag clear
// - format-bad-track sets bad flag in ids
// - seek starts positioning and selects head
// - buffered seek completes once steps issued
// - command waits busy for seek; ready-test reports 08
// - no timeout on buffered seek wait
// - step spacing 70us, 200us or 3ms
// - codes 00, 03 write fault, 04 not ready
// - no track zero after cyl+200 steps gives 06
// - code 12 missing mark, 15 id mismatch
// - code 11 uncorrectable, 18 corrected
// - bad track gives 19, no retry
// - code 20 bad command, 21 bad address
// - diagnostic failures codes 30, 31, 32
// - ten retries; id miss adds rezero and ten more
module dcs_unit
  import dcs_pkg::*;
#(
  parameter int SLOW_CYC = STEP_SLOW_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_op,
  input wire logic cmd_drive,
  input wire logic [2:0] cmd_head,
  input wire logic [9:0] cmd_cyl,
  input wire logic [5:0] cmd_sector,
  input wire logic [7:0] cmd_count,
  input wire logic general_retry_disable,
  input wire logic [2:0] cmd_step_code,
  input wire logic [9:0] cfg_max_cyl,
  input wire logic [3:0] cfg_max_heads,
  input wire logic track_zero_indicator,
  input wire logic drive_selected_response,
  input wire logic seek_complete_signal,
  input wire logic drive_ready,
  input wire logic write_fault,
  input wire logic sec_done,
  input wire logic [5:0] sec_err,
  input wire logic diag_done,
  input wire logic [5:0] diag_err,
  input wire logic stat_rd,
  output logic busy,
  output logic done,
  output logic error,
  output logic [7:0] stat_data,
  output logic stat_valid,
  output logic step_pulse,
  output logic step_dir_in,
  output logic drive_sel,
  output logic [2:0] head_sel,
  output logic sec_go,
  output logic sec_write,
  output logic sec_format,
  output logic fmt_bad_flag,
  output logic [5:0] sec_target,
  output logic diag_go
);
  typedef enum logic [8:0] {
    ST_IDLE = 9'b000000001,
    ST_HOLD = 9'b000000010,
    ST_RECAL = 9'b000000100,
    ST_SEEK = 9'b000001000,
    ST_XFER = 9'b000010000,
    ST_WAITSEC = 9'b000100000,
    ST_DIAG = 9'b001000000,
    ST_FINISH = 9'b010000000,
    ST_STATUS = 9'b100000000
  } dcs_state_e;

  // ---------------------------------------------------------------
  // sync drive inputs
  // ---------------------------------------------------------------
  logic [4:0] sy1_q, sy2_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sy1_q <= 5'h00;
      sy2_q <= 5'h00;
    end else begin
      sy1_q <= {track_zero_indicator, drive_selected_response, seek_complete_signal,
                drive_ready, write_fault};
      sy2_q <= sy1_q;
    end
  end
  wire tk0_s = sy2_q[4];
  wire drive_selected_response_s = sy2_q[3];
  wire sc_s = sy2_q[2];
  wire rdy_s = sy2_q[1];
  wire wf_s = sy2_q[0];

  dcs_state_e st_q;
  logic [7:0] op_q;
  logic drv_q, r1_q, is_fmt_q, addr_cmd_q;
  logic [2:0] head_q, step_q;
  logic [9:0] cyl_q;
  logic [9:0] cur_cyl_q [2];
  logic [5:0] sec_q, err_q;
  logic [8:0] left_q;
  logic [3:0] retry_q;
  logic rezero_q;
  logic [1:0] pend_q; // buffered seek outstanding per drive
  logic [1:0] rd_idx_q;
  logic [2:0] rd_cnt_q;
  logic stp_start_q, recal_q;
  logic [10:0] stp_steps_q;
  logic [10:0] recal_cnt_q;
  logic st_we_q;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  wire op_known = (cmd_op == OP_TEST_READY) || (cmd_op == OP_RECAL) ||
                  (cmd_op == OP_READ_STATUS) || (cmd_op == OP_FMT_DRIVE) ||
                  (cmd_op == OP_VERIFY) || (cmd_op == OP_FMT_TRACK) ||
                  (cmd_op == OP_FMT_BAD) || (cmd_op == OP_READ) ||
                  (cmd_op == OP_WRITE) || (cmd_op == OP_SEEK) ||
                  (cmd_op[7:5] == 3'b111);
  wire op_addr = (cmd_op >= OP_FMT_DRIVE) && (cmd_op <= OP_SEEK);
  wire addr_bad = op_addr && ((cmd_cyl >= cfg_max_cyl) ||
                  ({1'b0, cmd_head} >= cfg_max_heads) ||
                  (9'(cmd_sector) >= SECTORS_PER_TRACK));
  wire [8:0] count_full = (cmd_count == 8'h00) ? 9'd256 : {1'b0, cmd_count};
  wire op_fmt = (cmd_op == OP_FMT_DRIVE) || (cmd_op == OP_FMT_TRACK) ||
                (cmd_op == OP_FMT_BAD);
  wire seek_wait = pend_q[cmd_drive] && !sc_s;
  wire [10:0] seek_dist = (cyl_q >= cur_cyl_q[drv_q]) ?
                          {1'b0, cyl_q - cur_cyl_q[drv_q]} :
                          {1'b0, cur_cyl_q[drv_q] - cyl_q};
  wire [10:0] recal_lim = {1'b0, cfg_max_cyl} + 11'(TRK0_EXTRA_STEPS);
  wire retriable = !r1_q && (sec_err != ERR_BAD_TRK) && (sec_err != ERR_CORR) &&
                   ((retry_q < RETRY_LIMIT) || (sec_err == ERR_SEEK && !rezero_q));
  wire stp_busy;
  wire [31:0] st_word = {cyl_q[7:0], cyl_q[9:8], sec_q, 2'b00, drv_q,
                         2'b00, head_q, addr_cmd_q, 1'b0, err_q};

  dcs_stepper #(.SLOW_CYC(SLOW_CYC)) u_step (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(stp_start_q),
    .steps(stp_steps_q),
    .step_code(recal_q ? 3'b000 : step_q),
    .stop(recal_q && tk0_s),
    .step_pulse(step_pulse),
    .busy(stp_busy)
  );

  wire [7:0] mem_rd;
  dcs_status_mem u_mem (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(st_we_q),
    .wr_drive(drv_q),
    .wr_data(st_word),
    .rd_drive(drv_q),
    .rd_idx(rd_idx_q),
    .rd_data(mem_rd)
  );

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      op_q <= 8'h00; drv_q <= 1'b0; r1_q <= 1'b0; is_fmt_q <= 1'b0;
      addr_cmd_q <= 1'b0; head_q <= 3'h0; step_q <= 3'h0; cyl_q <= 10'h000;
      cur_cyl_q[0] <= 10'h000; cur_cyl_q[1] <= 10'h000;
      sec_q <= 6'h00; err_q <= 6'h00; left_q <= 9'h000; retry_q <= 4'h0;
      rezero_q <= 1'b0; pend_q <= 2'b00; rd_idx_q <= 2'h0; rd_cnt_q <= 3'h0;
      stp_start_q <= 1'b0; recal_q <= 1'b0; stp_steps_q <= 11'h000;
      recal_cnt_q <= 11'h000; st_we_q <= 1'b0;
      busy <= 1'b0; done <= 1'b0; error <= 1'b0; stat_data <= 8'h00;
      stat_valid <= 1'b0; step_dir_in <= 1'b0; drive_sel <= 1'b0;
      head_sel <= 3'h0; sec_go <= 1'b0; sec_write <= 1'b0;
      sec_format <= 1'b0; fmt_bad_flag <= 1'b0; sec_target <= 6'h00;
      diag_go <= 1'b0;
    end else begin
      stp_start_q <= 1'b0;
      st_we_q <= 1'b0;
      done <= 1'b0;
      sec_go <= 1'b0;
      diag_go <= 1'b0;
      stat_valid <= 1'b0;
      // seek complete clears the outstanding mark of the selected drive
      if (sc_s) pend_q[drive_sel] <= 1'b0;
      unique case (st_q)
        ST_IDLE: if (cmd_valid) begin
          busy <= 1'b1;
          op_q <= cmd_op; drv_q <= cmd_drive; head_q <= cmd_head;
          cyl_q <= cmd_cyl; r1_q <= general_retry_disable; step_q <= cmd_step_code;
          sec_q <= op_fmt ? 6'h00 : cmd_sector;
          left_q <= op_fmt ? 9'(SECTORS_PER_TRACK) : count_full;
          is_fmt_q <= op_fmt; addr_cmd_q <= op_addr;
          fmt_bad_flag <= (cmd_op == OP_FMT_BAD);
          retry_q <= 4'h0; rezero_q <= 1'b0; err_q <= ERR_NONE;
          drive_sel <= cmd_drive; head_sel <= cmd_head;
          if (cmd_op == OP_READ_STATUS) begin
            rd_idx_q <= 2'h0; rd_cnt_q <= 3'h0; addr_cmd_q <= 1'b0;
            st_q <= ST_STATUS;
          end else if (!op_known) begin
            err_q <= ERR_INV_CMD; st_q <= ST_FINISH;
          end else if (addr_bad) begin
            err_q <= ERR_ILL_ADDR; st_q <= ST_FINISH;
          end else if (cmd_op == OP_TEST_READY && seek_wait) begin
            err_q <= ERR_SEEKING; st_q <= ST_FINISH;
          end else st_q <= seek_wait ? ST_HOLD : ST_RECAL;
        end
        // no timeout here: only seek complete releases the hold
        ST_HOLD: if (sc_s) st_q <= ST_RECAL;
        ST_RECAL: begin
          if (!drive_selected_response_s || !rdy_s) begin
            err_q <= ERR_NOT_READY; st_q <= ST_FINISH;
          end else if (wf_s) begin
            err_q <= ERR_WFAULT; st_q <= ST_FINISH;
          end else if (is_fmt_q || op_q == OP_RECAL || rezero_q) begin
            if (!recal_q) begin
              recal_q <= 1'b1; step_dir_in <= 1'b0; recal_cnt_q <= 11'h000;
              stp_steps_q <= recal_lim; stp_start_q <= 1'b1;
            end else if (tk0_s && !stp_start_q) begin
              recal_q <= 1'b0; cur_cyl_q[drv_q] <= 10'h000; st_q <= ST_SEEK;
            end else if (step_pulse && recal_cnt_q != recal_lim) begin
              recal_cnt_q <= recal_cnt_q + 11'h001;
            end else if (!stp_busy && !stp_start_q) begin
              recal_q <= 1'b0; err_q <= ERR_TRK0; st_q <= ST_FINISH;
            end
          end else st_q <= ST_SEEK;
        end
        ST_SEEK: if (!stp_start_q && !stp_busy) begin
          if (cur_cyl_q[drv_q] != cyl_q) begin
            step_dir_in <= (cyl_q > cur_cyl_q[drv_q]);
            stp_steps_q <= seek_dist; stp_start_q <= 1'b1;
            cur_cyl_q[drv_q] <= cyl_q;
          end else if (op_q == OP_SEEK) begin
            // buffered drive moves alone; report once pulses are out
            pend_q[drv_q] <= 1'b1; st_q <= ST_FINISH;
          end else if (op_q == OP_RECAL) st_q <= ST_FINISH;
          else if (op_q[7:5] == 3'b111) begin
            diag_go <= 1'b1; st_q <= ST_DIAG;
          end else st_q <= ST_XFER;
        end
        ST_XFER: begin
          sec_go <= 1'b1; sec_target <= sec_q;
          sec_write <= (op_q == OP_WRITE) || is_fmt_q;
          sec_format <= is_fmt_q;
          st_q <= ST_WAITSEC;
        end
        ST_WAITSEC: if (sec_done) begin
          if (sec_err == ERR_NONE || sec_err == ERR_CORR) begin
            if (sec_err == ERR_CORR) err_q <= ERR_CORR;
            retry_q <= 4'h0;
            if (9'(sec_q) + 9'h001 >= SECTORS_PER_TRACK) begin
              sec_q <= 6'h00;
              if ({1'b0, head_q} + 4'h1 >= cfg_max_heads || is_fmt_q && op_q != OP_FMT_DRIVE) begin
                head_q <= 3'h0; cyl_q <= cyl_q + 10'h001;
              end else head_q <= head_q + 3'h1;
            end else sec_q <= sec_q + 6'h01;
            if (is_fmt_q) begin
              // format runs track by track; drive format to last cylinder
              if (9'(sec_q) + 9'h001 >= SECTORS_PER_TRACK &&
                  (op_q != OP_FMT_DRIVE || cyl_q + 10'h001 >= cfg_max_cyl))
                st_q <= ST_FINISH;
              else st_q <= (9'(sec_q) + 9'h001 >= SECTORS_PER_TRACK) ? ST_SEEK : ST_XFER;
            end else if (left_q == 9'h001) st_q <= ST_FINISH;
            else begin
              left_q <= left_q - 9'h001;
              st_q <= (9'(sec_q) + 9'h001 >= SECTORS_PER_TRACK) ? ST_SEEK : ST_XFER;
            end
          end else if (retriable) begin
            if (retry_q == RETRY_LIMIT) begin
              rezero_q <= 1'b1; retry_q <= 4'h0; st_q <= ST_RECAL;
            end else begin
              retry_q <= retry_q + 4'h1; st_q <= ST_XFER;
            end
          end else begin
            // address stays on failing sector / track
            err_q <= sec_err;
            if (is_fmt_q) sec_q <= 6'h00;
            st_q <= ST_FINISH;
          end
        end
        ST_DIAG: if (diag_done) begin
          err_q <= diag_err; st_q <= ST_FINISH;
        end
        ST_FINISH: begin
          st_we_q <= 1'b1;
          busy <= 1'b0; done <= 1'b1; error <= (err_q != ERR_NONE);
          st_q <= ST_IDLE;
        end
        ST_STATUS: begin
          // one registered read in flight, byte out per stat_rd
          if (rd_cnt_q == 3'(STATUS_BYTES)) begin
            busy <= 1'b0; done <= 1'b1; error <= 1'b0; st_q <= ST_IDLE;
          end else if (stat_rd) begin
            stat_data <= mem_rd; stat_valid <= 1'b1;
            rd_cnt_q <= rd_cnt_q + 3'h1; rd_idx_q <= rd_idx_q + 2'h1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule : dcs_unit

//--- dcs_unit_props.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// protocol checks on the command, status, step and sector ports
// ------------------------------------------------------------
module dcs_unit_props
  import dcs_pkg::*;
#(
  parameter int SLOW_CYC = 50
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_op,
  input wire logic [9:0] cmd_cyl,
  input wire logic [9:0] cfg_max_cyl,
  input wire logic stat_rd,
  input wire logic busy,
  input wire logic done,
  input wire logic error,
  input wire logic stat_valid,
  input wire logic step_pulse,
  input wire logic sec_go
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // a command counts only when the unit was idle on that edge
  wire take = cmd_valid && !busy;
  take_starts_busy_a: assert property (take |=> busy)
    else $error("busy did not follow an accepted command");
  done_ends_busy_a: assert property (done |-> !busy && $past(busy))
    else $error("done without busy falling");
  done_single_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  error_holds_a: assert property (!done |-> $stable(error))
    else $error("error changed outside done");
  bad_cmd_reject_a: assert property (take && cmd_op == 8'h02 |-> ##2 (done && error))
    else $error("unknown opcode not rejected in time");
  bad_addr_reject_a: assert property
    (take && cmd_op == OP_READ && cmd_cyl > cfg_max_cyl |-> ##2 (done && error))
    else $error("out of range address not rejected in time");
  stat_byte_timing_a: assert property (stat_valid |-> $past(stat_rd))
    else $error("status byte without a request");
  step_width_a: assert property ($rose(step_pulse) |-> step_pulse[*4] ##1 !step_pulse)
    else $error("step pulse width wrong");
  sec_in_cmd_a: assert property (sec_go |-> busy && !done)
    else $error("sector start outside a command");
endmodule : dcs_unit_props

//--- dcs_drive_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// behavioural drive: head position, settle, sector answers
// ------------------------------------------------------------
module dcs_drive_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic step_pulse,
  input wire logic step_dir_in,
  input wire logic sec_go,
  input wire logic [5:0] sec_target,
  input wire logic [5:0] fail_sector,
  input wire logic [5:0] fail_code,
  input wire logic [15:0] settle_cyc,
  output logic track_zero_indicator,
  output logic drive_selected_response,
  output logic seek_complete_signal,
  output logic drive_ready,
  output logic write_fault,
  output logic sec_done,
  output logic [5:0] sec_err
);
  logic [9:0] pos_q;
  logic [15:0] settle_q;
  logic step_q;
  logic [2:0] cnt_q;
  logic [5:0] tgt_q;
  // both drives present and healthy; faults come only as sector codes
  assign drive_selected_response = 1'b1;
  assign drive_ready = 1'b1;
  assign write_fault = 1'b0;
  assign track_zero_indicator = (pos_q == 10'h000);
  assign seek_complete_signal = (settle_q == 16'h0000) && !step_pulse;
  // settle restarts on every step; a sector answer is poisoned when idle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pos_q <= 10'h000;
      settle_q <= 16'h0000;
      step_q <= 1'b0;
      cnt_q <= 3'h0;
      tgt_q <= 6'h00;
      sec_done <= 1'b0;
      sec_err <= 6'h00;
    end else begin
      step_q <= step_pulse;
      sec_done <= 1'b0;
      sec_err <= ~sec_err;
      if (step_pulse && !step_q) begin
        pos_q <= step_dir_in ? pos_q + 10'h001 : pos_q - 10'h001;
        settle_q <= settle_cyc;
      end else if (settle_q != 16'h0000) begin
        settle_q <= settle_q - 16'h0001;
      end
      if (sec_go) begin
        cnt_q <= 3'h6;
        tgt_q <= sec_target;
      end else if (cnt_q == 3'h1) begin
        cnt_q <= 3'h0;
        sec_done <= 1'b1;
        sec_err <= (tgt_q == fail_sector) ? fail_code : 6'h00;
      end else if (cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end
endmodule : dcs_drive_model

//--- disk_command_status_unit_tb.sv
`timescale 1ns/1ns
module disk_command_status_unit_tb
  import dcs_pkg::*;
;
  // ------------------------------------------------------------
  // stimulus, drive model and bookkeeping
  // ------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_op = 8'h00;
  logic cmd_drive = 1'b0;
  logic [2:0] cmd_head = 3'h0;
  logic [9:0] cmd_cyl = 10'h000;
  logic [5:0] cmd_sector = 6'h00;
  logic [7:0] cmd_count = 8'h00;
  logic general_retry_disable = 1'b0;
  logic [2:0] cmd_step_code = 3'h0;
  logic [9:0] cfg_max_cyl = 10'h12c;
  logic [3:0] cfg_max_heads = 4'h4;
  logic stat_rd = 1'b0;
  logic [5:0] fail_sector = 6'h3f;
  logic [5:0] fail_code = 6'h00;
  logic [15:0] settle_cyc = 16'h0014;
  logic busy, done, error, stat_valid, step_pulse, step_dir_in, drive_sel;
  logic sec_go, sec_write, sec_format, fmt_bad_flag, sec_done;
  logic track_zero_indicator, drive_selected_response, seek_complete_signal;
  logic drive_ready, write_fault;
  logic [7:0] stat_data;
  logic [2:0] head_sel;
  logic [5:0] sec_target, sec_err;
  logic [7:0] st [4];
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int gos = 0;
  int bads = 0;

  // short slow step spacing keeps recalibration cheap in simulation
  dcs_unit #(.SLOW_CYC(50)) dut (.clk_sys, .rst, .cmd_valid, .cmd_op, .cmd_drive, .cmd_head,
    .cmd_cyl, .cmd_sector, .cmd_count, .general_retry_disable, .cmd_step_code, .cfg_max_cyl,
    .cfg_max_heads, .track_zero_indicator, .drive_selected_response, .seek_complete_signal,
    .drive_ready, .write_fault, .sec_done, .sec_err, .diag_done(1'b0), .diag_err(6'h00),
    .stat_rd, .busy, .done, .error, .stat_data, .stat_valid, .step_pulse, .step_dir_in,
    .drive_sel, .head_sel, .sec_go, .sec_write, .sec_format, .fmt_bad_flag, .sec_target,
    .diag_go());
  dcs_drive_model u_drive (.clk_sys, .rst, .step_pulse, .step_dir_in, .sec_go, .sec_target,
    .fail_sector, .fail_code, .settle_cyc, .track_zero_indicator, .drive_selected_response,
    .seek_complete_signal, .drive_ready, .write_fault, .sec_done, .sec_err);

  always #5 clk_sys = ~clk_sys;
  // sector starts, bad-flag writes and the hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (sec_go) gos++;
    if (sec_go && sec_format && fmt_bad_flag) bads++;
    if (cycles == 60000) begin
      mismatches++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one-cycle request at the falling edge, taken on the next rising edge
  task automatic issue(input logic [7:0] op, input logic [9:0] cyl, input logic [2:0] hd,
      input logic [5:0] sec, input logic [7:0] cnt, input logic dis, input logic [2:0] sc);
    @(negedge clk_sys);
    cmd_op = op;
    cmd_cyl = cyl;
    cmd_head = hd;
    cmd_sector = sec;
    cmd_count = cnt;
    general_retry_disable = dis;
    cmd_step_code = sc;
    gos = 0;
    bads = 0;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
  endtask : issue

  task automatic wait_done();
    while (done !== 1'b1) @(negedge clk_sys);
  endtask : wait_done

  // requests are repeated because a held command ignores them
  task automatic get_status();
    int k;
    issue(OP_READ_STATUS, 10'h000, 3'h0, 6'h00, 8'h00, 1'b0, 3'h0);
    for (int i = 0; i < 4; i++) begin
      k = 0;
      while (stat_valid !== 1'b1) begin
        stat_rd = (k % 4 == 0);
        @(negedge clk_sys);
        k++;
      end
      st[i] = stat_data;
      stat_rd = 1'b0;
      @(negedge clk_sys);
    end
    wait_done();
  endtask : get_status

  // one command, then its status block; esec 3f skips the address check
  task automatic run(input logic [7:0] op, input logic [9:0] cyl, input logic [5:0] sec,
      input logic [7:0] cnt, input logic [5:0] fs, input logic [5:0] fc, input logic dis,
      input int go, input int bad, input logic [5:0] code, input logic [5:0] esec);
    fail_sector = fs;
    fail_code = fc;
    issue(op, cyl, 3'h0, sec, cnt, dis, 3'h0);
    wait_done();
    check(error, code != 6'h00);
    check(gos, go);
    check(bads, bad);
    fail_sector = 6'h3f;
    get_status();
    check(st[0][5:0], code);
    if (esec != 6'h3f) begin
      check(st[0], {2'b10, code});
      check(st[2], {cyl[9:8], esec});
      check(st[3], cyl[7:0]);
    end
  endtask : run

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    run(OP_FMT_BAD, 10'h002, 6'h00, 8'h01, 6'h3f, 6'h00, 1'b1, 17, 17, 6'h00, 6'h3f);
    run(OP_FMT_TRACK, 10'h003, 6'h00, 8'h01, 6'h3f, 6'h00, 1'b1, 17, 0, 6'h00, 6'h3f);
    run(OP_READ, 10'h002, 6'h01, 8'h04, 6'h03, ERR_UNCORR, 1'b1, 3, 0, ERR_UNCORR, 6'h03);
    run(OP_READ, 10'h002, 6'h01, 8'h04, 6'h03, ERR_NO_DAM, 1'b1, 3, 0, ERR_NO_DAM, 6'h03);
    run(OP_READ, 10'h002, 6'h01, 8'h04, 6'h03, ERR_SEEK, 1'b1, 3, 0, ERR_SEEK, 6'h03);
    run(OP_READ, 10'h002, 6'h01, 8'h04, 6'h03, ERR_BAD_TRK, 1'b0, 3, 0, ERR_BAD_TRK, 6'h03);
    run(OP_READ, 10'h002, 6'h03, 8'h02, 6'h3f, 6'h00, 1'b1, 2, 0, 6'h00, 6'h3f);
    run(OP_READ, 10'h002, 6'h01, 8'h04, 6'h03, ERR_NO_DAM, 1'b0, 13, 0, ERR_NO_DAM, 6'h03);
    run(OP_WRITE, 10'h002, 6'h05, 8'h03, 6'h06, ERR_NO_DAM, 1'b1, 2, 0, ERR_NO_DAM, 6'h06);
    run(OP_VERIFY, 10'h002, 6'h01, 8'h04, 6'h02, ERR_UNCORR, 1'b1, 2, 0, ERR_UNCORR, 6'h3f);
    run(OP_READ, 10'h190, 6'h01, 8'h01, 6'h3f, 6'h00, 1'b1, 0, 0, ERR_ILL_ADDR, 6'h3f);
    run(8'h02, 10'h000, 6'h00, 8'h01, 6'h3f, 6'h00, 1'b1, 0, 0, ERR_INV_CMD, 6'h3f);
    // buffered seek: settle outlasts the command
    settle_cyc = 16'd8000;
    issue(OP_SEEK, 10'h003, 3'h2, 6'h00, 8'h00, 1'b0, STEP_CODE_70US);
    wait_done();
    check(error, 1'b0);
    check(head_sel, 3'h2);
    check(seek_complete_signal, 1'b0);
    issue(OP_TEST_READY, 10'h000, 3'h0, 6'h00, 8'h00, 1'b0, 3'h0);
    wait_done();
    check(error, 1'b1);
    get_status();
    check(st[0], {2'b00, ERR_SEEKING});
    issue(OP_READ, 10'h003, 3'h0, 6'h00, 8'h01, 1'b1, 3'h0);
    wait_done();
    check(seek_complete_signal, 1'b1);
    stop_test();
  end
endmodule : disk_command_status_unit_tb

bind dcs_unit dcs_unit_props #(.SLOW_CYC(SLOW_CYC)) u_props (.clk_sys, .rst, .cmd_valid,
  .cmd_op, .cmd_cyl, .cfg_max_cyl, .stat_rd, .busy, .done, .error, .stat_valid, .step_pulse,
  .sec_go);
